// [hdl/src_pkg.sv]
// Shared constants and the CRC-8 byte step for the sensor block read
package src_pkg;

  // ==========================================================================
  // Widths and counts
  // ==========================================================================
  localparam int          BYTE_W     = 8;
  localparam int          ADDR_W     = 8;
  localparam int          DATA_BYTES = 4;
  localparam int          FIFO_DEPTH = 8;
  localparam logic [1:0]  LAST_IDX   = 2'h3;

  // ==========================================================================
  // CRC constants
  // ==========================================================================
  localparam logic [7:0]  CRC_SEED   = 8'hFF;

  // One byte folded into the CRC, polynomial x^8+x^2+x+1, bit-parallel
  function automatic logic [7:0] crc8_step(input logic [7:0] c, input logic [7:0] d);
    logic [7:0] n;
    n[0] = d[7] ^ d[6] ^ d[0] ^ c[0] ^ c[6] ^ c[7];
    n[1] = d[6] ^ d[1] ^ d[0] ^ c[0] ^ c[1] ^ c[6];
    n[2] = d[6] ^ d[2] ^ d[1] ^ d[0] ^ c[0] ^ c[1] ^ c[2] ^ c[6];
    n[3] = d[7] ^ d[3] ^ d[2] ^ d[1] ^ c[1] ^ c[2] ^ c[3] ^ c[7];
    n[4] = d[4] ^ d[3] ^ d[2] ^ c[2] ^ c[3] ^ c[4];
    n[5] = d[5] ^ d[4] ^ d[3] ^ c[3] ^ c[4] ^ c[5];
    n[6] = d[6] ^ d[5] ^ d[4] ^ c[4] ^ c[5] ^ c[6];
    n[7] = d[7] ^ d[6] ^ d[5] ^ c[5] ^ c[6] ^ c[7];
    return n;
  endfunction

endpackage

// [hdl/src_link_if.sv]
// Link between the host end and the sensor end: read request and byte stream
`timescale 1ns/10ps
interface src_link_if;

  // Read request, host to sensor
  logic                           reqValid;
  logic                           reqReady;
  logic [src_pkg::ADDR_W-1:0]     reqAddr;

  // Returned bytes, sensor to host
  logic                           datValid;
  logic                           datReady;
  logic [src_pkg::BYTE_W-1:0]     datByte;
  logic                           datLast;

  modport dev (
    input  reqValid,
    output reqReady,
    input  reqAddr,
    output datValid,
    input  datReady,
    output datByte,
    output datLast
  );

  modport host (
    output reqValid,
    input  reqReady,
    output reqAddr,
    input  datValid,
    output datReady,
    input  datByte,
    input  datLast
  );

endinterface

// [hdl/src_dev_end.sv]
// Sensor end of the block read: register fetch, CRC append, output FIFO
`timescale 1ns/10ps

// ============================================================================
// Output FIFO
// ============================================================================
module src_fifo #(
  parameter int WIDTH = 9,
  parameter int DEPTH = src_pkg::FIFO_DEPTH
) (
  // Clock and reset
  input  wire logic             ref_clk,
  input  wire logic             rstn,
  // Fill side
  input  wire logic             inValid,
  output logic                  inReady,
  input  wire logic [WIDTH-1:0] inData,
  // Drain side
  output logic                  outValid,
  input  wire logic             outReady,
  output logic [WIDTH-1:0]      outData
);

  localparam int             PW       = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam int             CW       = $clog2(DEPTH + 1);
  localparam logic [CW-1:0]  FULL_CNT = CW'(DEPTH);
  localparam logic [PW-1:0]  LAST_PTR = PW'(DEPTH - 1);

  logic [WIDTH-1:0] mem_r   [DEPTH];
  logic [WIDTH-1:0] mem_nxt [DEPTH];
  logic [PW-1:0]    wrPtr_r;
  logic [PW-1:0]    wrPtr_nxt;
  logic [PW-1:0]    rdPtr_r;
  logic [PW-1:0]    rdPtr_nxt;
  logic [CW-1:0]    count_r;
  logic [CW-1:0]    count_nxt;
  logic             doWr;
  logic             doRd;

  assign inReady  = (count_r != FULL_CNT);
  assign outValid = (count_r != '0);
  assign outData  = mem_r[rdPtr_r];
  assign doWr     = inValid & inReady;
  assign doRd     = outValid & outReady;

  always_comb begin
    mem_nxt   = mem_r;
    wrPtr_nxt = wrPtr_r;
    rdPtr_nxt = rdPtr_r;
    count_nxt = count_r;
    if (doWr) begin
      mem_nxt[wrPtr_r] = inData;
      wrPtr_nxt        = (wrPtr_r == LAST_PTR) ? '0 : wrPtr_r + 1'b1;
    end
    if (doRd) begin
      rdPtr_nxt = (rdPtr_r == LAST_PTR) ? '0 : rdPtr_r + 1'b1;
    end
    if (doWr && !doRd) begin
      count_nxt = count_r + 1'b1;
    end else if (doRd && !doWr) begin
      count_nxt = count_r - 1'b1;
    end
  end

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      for (int i = 0; i < DEPTH; i++) begin
        mem_r[i] <= '0;
      end
      wrPtr_r <= '0;
      rdPtr_r <= '0;
      count_r <= '0;
    end else begin
      mem_r   <= mem_nxt;
      wrPtr_r <= wrPtr_nxt;
      rdPtr_r <= rdPtr_nxt;
      count_r <= count_nxt;
    end
  end

endmodule

// ============================================================================
// Sensor end
// ============================================================================
// What this block does
// - Send start register and next three registers
// - CRC covers exactly the four bytes sent
// - CRC accumulator starts at all ones
// - CRC bit 0 equation
// - CRC bits 1 and 2 equations
// - CRC bits 3 and 4 equations
// - CRC bits 5 and 7 equations
// - Only the final CRC is sent
// - Host enables channels before reading data
// - CRC appended only when enabled and standard
module src_dev_end #(
  parameter int DEPTH = src_pkg::FIFO_DEPTH
) (
  // Clock and reset
  input  wire logic                       ref_clk,
  input  wire logic                       rstn,
  // Link to the host end
  src_link_if.dev                         link,
  // Configuration from the sensor logic
  input  wire logic                       crcEnable,
  input  wire logic                       stdReadMode,
  // Register file read port, data one cycle after the enable
  output logic                            regRdEn,
  output logic [src_pkg::ADDR_W-1:0]      regAddr,
  input  wire logic [src_pkg::BYTE_W-1:0] regRdData,
  // Status
  output logic                            busy
);

  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_READ = 3'b001,
    ST_CAPT = 3'b010,
    ST_PUSH = 3'b011,
    ST_CRC  = 3'b100
  } src_dev_state_type;

  localparam int FW = src_pkg::BYTE_W + 1;

  src_dev_state_type               state_r;
  src_dev_state_type               state_nxt;
  logic [src_pkg::ADDR_W-1:0]      addr_r;
  logic [src_pkg::ADDR_W-1:0]      addr_nxt;
  logic [1:0]                      idx_r;
  logic [1:0]                      idx_nxt;
  logic [src_pkg::BYTE_W-1:0]      byte_r;
  logic [src_pkg::BYTE_W-1:0]      byte_nxt;
  logic [src_pkg::BYTE_W-1:0]      crc_r;
  logic [src_pkg::BYTE_W-1:0]      crc_nxt;
  logic                            append_r;
  logic                            append_nxt;
  logic                            fifoInValid;
  logic                            fifoInReady;
  logic [FW-1:0]                   fifoInData;
  logic [FW-1:0]                   fifoOutData;
  logic                            lastData;

  // ==========================================================================
  // Sequencer
  // ==========================================================================
  assign link.reqReady = (state_r == ST_IDLE);
  assign regRdEn       = (state_r == ST_READ);
  assign regAddr       = addr_r;
  assign busy          = (state_r != ST_IDLE);
  // Without CRC the fourth data byte closes the frame
  assign lastData      = (idx_r == src_pkg::LAST_IDX) && !append_r;

  always_comb begin
    state_nxt   = state_r;
    addr_nxt    = addr_r;
    idx_nxt     = idx_r;
    byte_nxt    = byte_r;
    crc_nxt     = crc_r;
    append_nxt  = append_r;
    fifoInValid = 1'b0;
    fifoInData  = '0;
    case (state_r)
      ST_IDLE: begin
        if (link.reqValid) begin
          addr_nxt   = link.reqAddr;
          idx_nxt    = '0;
          crc_nxt    = src_pkg::CRC_SEED;
          // Mode sampled once per read so a frame never changes shape
          append_nxt = crcEnable & stdReadMode;
          state_nxt  = ST_READ;
        end
      end
      ST_READ: begin
        state_nxt = ST_CAPT;
      end
      ST_CAPT: begin
        byte_nxt  = regRdData;
        crc_nxt   = src_pkg::crc8_step(crc_r, regRdData);
        state_nxt = ST_PUSH;
      end
      ST_PUSH: begin
        fifoInValid = 1'b1;
        fifoInData  = {lastData, byte_r};
        if (fifoInReady) begin
          if (idx_r == src_pkg::LAST_IDX) begin
            state_nxt = append_r ? ST_CRC : ST_IDLE;
          end else begin
            // Address wraps at the top of the map
            idx_nxt   = idx_r + 1'b1;
            addr_nxt  = addr_r + 1'b1;
            state_nxt = ST_READ;
          end
        end
      end
      ST_CRC: begin
        // Intermediate values never leave the block
        fifoInValid = 1'b1;
        fifoInData  = {1'b1, crc_r};
        if (fifoInReady) begin
          state_nxt = ST_IDLE;
        end
      end
      default: begin
        state_nxt = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      state_r  <= ST_IDLE;
      addr_r   <= '0;
      idx_r    <= '0;
      byte_r   <= '0;
      crc_r    <= src_pkg::CRC_SEED;
      append_r <= 1'b0;
    end else begin
      state_r  <= state_nxt;
      addr_r   <= addr_nxt;
      idx_r    <= idx_nxt;
      byte_r   <= byte_nxt;
      crc_r    <= crc_nxt;
      append_r <= append_nxt;
    end
  end

  // ==========================================================================
  // Output buffer
  // ==========================================================================
  // A slow host stalls the sequencer through fifoInReady
  src_fifo #(
    .WIDTH (FW),
    .DEPTH (DEPTH)
  ) uFifo (
    .ref_clk  (ref_clk),
    .rstn     (rstn),
    .inValid  (fifoInValid),
    .inReady  (fifoInReady),
    .inData   (fifoInData),
    .outValid (link.datValid),
    .outReady (link.datReady),
    .outData  (fifoOutData)
  );

  assign link.datByte = fifoOutData[src_pkg::BYTE_W-1:0];
  assign link.datLast = fifoOutData[src_pkg::BYTE_W];

endmodule

// [hdl/src_host_end.sv]
// Host end of the block read: request, collect bytes, recompute and check CRC
`timescale 1ns/10ps
module src_host_end (
  // Clock and reset
  input  wire logic                       ref_clk,
  input  wire logic                       rstn,
  // Link to the sensor end
  src_link_if.host                        link,
  // Command from user logic
  input  wire logic                       startRead,
  input  wire logic [src_pkg::ADDR_W-1:0] startAddr,
  input  wire logic                       channelsEnabled,
  input  wire logic                       pauseRx,
  // Result to user logic
  output logic                            busy,
  output logic                            rdDone,
  output logic [31:0]                     rdWord,
  output logic [src_pkg::BYTE_W-1:0]      rdCrc,
  output logic                            crcPresent,
  output logic                            crcMatch
);

  typedef enum logic [1:0] {
    HS_IDLE = 2'b00,
    HS_REQ  = 2'b01,
    HS_RECV = 2'b10
  } src_host_state_type;

  src_host_state_type              state_r;
  src_host_state_type              state_nxt;
  logic [src_pkg::ADDR_W-1:0]      addr_r;
  logic [src_pkg::ADDR_W-1:0]      addr_nxt;
  logic [2:0]                      cnt_r;
  logic [2:0]                      cnt_nxt;
  logic [src_pkg::BYTE_W-1:0]      crc_r;
  logic [src_pkg::BYTE_W-1:0]      crc_nxt;
  logic [31:0]                     word_r;
  logic [31:0]                     word_nxt;
  logic [src_pkg::BYTE_W-1:0]      rxCrc_r;
  logic [src_pkg::BYTE_W-1:0]      rxCrc_nxt;
  logic                            present_r;
  logic                            present_nxt;
  logic                            match_r;
  logic                            match_nxt;
  logic                            done_r;
  logic                            done_nxt;
  logic                            take;

  // ==========================================================================
  // Request and receive
  // ==========================================================================
  assign link.reqValid = (state_r == HS_REQ);
  assign link.reqAddr  = addr_r;
  assign link.datReady = (state_r == HS_RECV) && !pauseRx;
  assign take          = link.datValid && link.datReady;
  assign busy          = (state_r != HS_IDLE);
  assign rdDone        = done_r;
  assign rdWord        = word_r;
  assign rdCrc         = rxCrc_r;
  assign crcPresent    = present_r;
  assign crcMatch      = match_r;

  always_comb begin
    state_nxt   = state_r;
    addr_nxt    = addr_r;
    cnt_nxt     = cnt_r;
    crc_nxt     = crc_r;
    word_nxt    = word_r;
    rxCrc_nxt   = rxCrc_r;
    present_nxt = present_r;
    match_nxt   = match_r;
    done_nxt    = 1'b0;
    case (state_r)
      HS_IDLE: begin
        // Data read with channels off is meaningless, so no request
        if (startRead && channelsEnabled) begin
          addr_nxt    = startAddr;
          cnt_nxt     = '0;
          crc_nxt     = src_pkg::CRC_SEED;
          present_nxt = 1'b0;
          match_nxt   = 1'b0;
          state_nxt   = HS_REQ;
        end
      end
      HS_REQ: begin
        if (link.reqReady) begin
          state_nxt = HS_RECV;
        end
      end
      HS_RECV: begin
        if (take) begin
          if (cnt_r < 3'(src_pkg::DATA_BYTES)) begin
            word_nxt = {word_r[23:0], link.datByte};
            crc_nxt  = src_pkg::crc8_step(crc_r, link.datByte);
            cnt_nxt  = cnt_r + 1'b1;
          end else begin
            // Fifth byte is the sensor's check value
            rxCrc_nxt   = link.datByte;
            present_nxt = 1'b1;
            match_nxt   = (link.datByte == crc_r);
          end
          if (link.datLast) begin
            done_nxt  = 1'b1;
            state_nxt = HS_IDLE;
          end
        end
      end
      default: begin
        state_nxt = HS_IDLE;
      end
    endcase
  end

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      state_r   <= HS_IDLE;
      addr_r    <= '0;
      cnt_r     <= '0;
      crc_r     <= src_pkg::CRC_SEED;
      word_r    <= '0;
      rxCrc_r   <= '0;
      present_r <= 1'b0;
      match_r   <= 1'b0;
      done_r    <= 1'b0;
    end else begin
      state_r   <= state_nxt;
      addr_r    <= addr_nxt;
      cnt_r     <= cnt_nxt;
      crc_r     <= crc_nxt;
      word_r    <= word_nxt;
      rxCrc_r   <= rxCrc_nxt;
      present_r <= present_nxt;
      match_r   <= match_nxt;
      done_r    <= done_nxt;
    end
  end

endmodule

// [testbench/src_link_asserts.sv]
// Link checker for the sensor block read with CRC byte
`timescale 1ns/10ps
module src_link_asserts (
  // Clock and reset
  input wire logic       ref_clk,
  input wire logic       rstn,
  // Link signals
  input wire logic       reqValid,
  input wire logic       reqReady,
  input wire logic [7:0] reqAddr,
  input wire logic       datValid,
  input wire logic       datReady,
  input wire logic [7:0] datByte,
  input wire logic       datLast
);
  logic [2:0] byteCnt_r;
  logic [2:0] byteCnt_nxt;
  logic [7:0] crcAcc_r;
  logic [7:0] crcAcc_nxt;
  logic       taken;

  // Serial form, kept apart from the design's parallel step
  function automatic logic [7:0] crcFold(input logic [7:0] c, input logic [7:0] d);
    logic [7:0] r;
    r = c ^ d;
    for (int i = 0; i < 8; i++) begin
      r = r[7] ? ({r[6:0], 1'b0} ^ 8'h07) : {r[6:0], 1'b0};
    end
    return r;
  endfunction

  // ==========
  // Frame tracking
  assign taken = datValid && datReady;
  always_comb begin
    byteCnt_nxt = byteCnt_r;
    crcAcc_nxt = crcAcc_r;
    if (taken && datLast) begin
      byteCnt_nxt = 3'h0;
      crcAcc_nxt = 8'hFF;
    end else if (taken) begin
      byteCnt_nxt = byteCnt_r + 3'h1;
      crcAcc_nxt = crcFold(crcAcc_r, datByte);
    end
  end
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      byteCnt_r <= 3'h0;
      crcAcc_r <= 8'hFF;
    end else begin
      byteCnt_r <= byteCnt_nxt;
      crcAcc_r <= crcAcc_nxt;
    end
  end

  // ==========
  // Properties
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rstn);

  a_req_hold: assert property (reqValid && !reqReady |=> reqValid && $stable(reqAddr))
    else $error("request dropped before acceptance");
  a_req_drop: assert property (reqValid && reqReady |=> !reqValid)
    else $error("request held after acceptance");
  a_busy_low: assert property (reqValid && reqReady |=> !reqReady [*3])
    else $error("second request accepted mid frame");
  a_first_lat: assert property (reqValid && reqReady |=> !datValid [*3] ##1 (datValid && !datLast))
    else $error("first byte not four cycles after request");
  a_frame_idle: assert property (reqValid && reqReady |-> byteCnt_r == 3'h0 && !datValid)
    else $error("request accepted with bytes outstanding");
  a_dat_stable: assert property (datValid && !datReady |=> datValid && $stable({datByte, datLast}))
    else $error("byte changed while stalled");
  a_early_last: assert property (taken && byteCnt_r < 3'h3 |-> !datLast)
    else $error("frame ended before four data bytes");
  a_last_count: assert property (taken && datLast |-> byteCnt_r == 3'h3 || byteCnt_r == 3'h4)
    else $error("frame length neither four nor five");
  a_crc_value: assert property (taken && byteCnt_r == 3'h4 |-> datLast && datByte == crcAcc_r)
    else $error("check byte differs from folded data");
  a_reset_quiet: assert property (disable iff (1'b0) !rstn |-> !datValid && !reqValid)
    else $error("link active during reset");

  c_with_crc: cover property (taken && datLast && byteCnt_r == 3'h4);
  c_no_crc: cover property (taken && datLast && byteCnt_r == 3'h3);
  c_stall: cover property (datValid && !datReady);
endmodule

// [testbench/sensor_read_crc8_tb.sv]
// Testbench for the sensor block read with CRC byte
`timescale 1ns/10ps
module sensor_read_crc8_tb;
  typedef struct packed {
    logic [31:0] word;
    logic [7:0]  crc;
    logic        present;
  } src_res_type;

  logic        ref_clk, rstn, crcEnable, stdReadMode, regRdEn, devBusy, pauseHold;
  logic        startRead, channelsEnabled, pauseRx, hostBusy, rdDone, crcPresent, crcMatch;
  logic [7:0]  regAddr, regRdData, startAddr, rdCrc;
  logic [31:0] rdWord, seed, pSeed;
  logic [7:0]  regMem [256];
  logic [8:0]  byteQ [$];
  src_res_type resQ [$];
  src_res_type expRes;
  int          errors, compares;

  function automatic logic [7:0] crcRef(input logic [7:0] c, input logic [7:0] d);
    logic [7:0] r;
    r = c ^ d;
    for (int i = 0; i < 8; i++) begin
      r = r[7] ? ({r[6:0], 1'b0} ^ 8'h07) : {r[6:0], 1'b0};
    end
    return r;
  endfunction

  function automatic logic [31:0] lfsrNext(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  // ==========
  // Design, link and checker
  src_link_if linkIf ();
  src_dev_end #(.DEPTH(src_pkg::FIFO_DEPTH)) src_dev_end_inst (
    .ref_clk(ref_clk), .rstn(rstn), .link(linkIf), .crcEnable(crcEnable),
    .stdReadMode(stdReadMode), .regRdEn(regRdEn), .regAddr(regAddr),
    .regRdData(regRdData), .busy(devBusy));
  src_host_end src_host_end_inst (
    .ref_clk(ref_clk), .rstn(rstn), .link(linkIf), .startRead(startRead),
    .startAddr(startAddr), .channelsEnabled(channelsEnabled), .pauseRx(pauseRx),
    .busy(hostBusy), .rdDone(rdDone), .rdWord(rdWord), .rdCrc(rdCrc),
    .crcPresent(crcPresent), .crcMatch(crcMatch));
  src_link_asserts src_link_asserts_inst (
    .ref_clk(ref_clk), .rstn(rstn), .reqValid(linkIf.reqValid),
    .reqReady(linkIf.reqReady), .reqAddr(linkIf.reqAddr), .datValid(linkIf.datValid),
    .datReady(linkIf.datReady), .datByte(linkIf.datByte), .datLast(linkIf.datLast));

  initial begin
    ref_clk = 1'b0;
    forever #2.5 ref_clk = ~ref_clk;
  end

  // Synchronous read, so data must stand the whole next cycle
  always @(posedge ref_clk) begin
    if (regRdEn === 1'b1) begin
      regRdData <= regMem[regAddr];
    end
  end

  always @(negedge ref_clk) begin
    pSeed = lfsrNext(pSeed);
    pauseRx = pauseHold | pSeed[0];
  end

  // ==========
  // Checking
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      errors++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic conclude();
    if (errors == 0 && compares > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  always @(posedge ref_clk) begin
    if (linkIf.datValid === 1'b1 && linkIf.datReady === 1'b1) begin
      if (byteQ.size() == 0) begin
        check("extraByte", 32'h1, 32'h0);
      end else begin
        check("datByte", {23'h0, linkIf.datLast, linkIf.datByte}, {23'h0, byteQ.pop_front()});
      end
    end
  end

  always @(negedge ref_clk) begin
    if (rdDone !== 1'b0) begin
      if (resQ.size() == 0) begin
        check("rdDone", 32'h1, 32'h0);
      end else begin
        expRes = resQ.pop_front();
        check("rdWord", rdWord, expRes.word);
        check("crcPresent", {31'h0, crcPresent}, {31'h0, expRes.present});
        check("crcMatch", {31'h0, crcMatch}, {31'h0, expRes.present});
        if (expRes.present) begin
          check("rdCrc", {24'h0, rdCrc}, {24'h0, expRes.crc});
        end
      end
    end
  end

  // ==========
  // Driving
  task automatic doRead(input logic [7:0] addr, input logic ce, input logic sm);
    src_res_type r;
    logic [7:0]  a;
    int          n;
    r.crc = 8'hFF;
    r.present = ce & sm;
    for (int i = 0; i < 4; i++) begin
      a = addr + 8'(i);
      r.word = {r.word[23:0], regMem[a]};
      r.crc = crcRef(r.crc, regMem[a]);
      byteQ.push_back({~r.present && i == 3, regMem[a]});
    end
    if (r.present) begin
      byteQ.push_back({1'b1, r.crc});
    end
    resQ.push_back(r);
    crcEnable = ce;
    stdReadMode = sm;
    startAddr = addr;
    startRead = 1'b1;
    @(negedge ref_clk);
    startRead = 1'b0;
    n = 0;
    while (rdDone !== 1'b1 && n < 400) begin
      @(negedge ref_clk);
      n++;
    end
    if (n == 400) begin
      check("rdDone", 32'h0, 32'h1);
      conclude();
    end
    @(negedge ref_clk);
  endtask

  initial begin
    seed = 32'h10c8_0d51;
    pSeed = ~seed;
    rstn = 1'b0;
    startRead = 1'b0;
    startAddr = 8'h00;
    crcEnable = 1'b1;
    stdReadMode = 1'b1;
    channelsEnabled = 1'b1;
    pauseHold = 1'b0;
    pauseRx = 1'b0;
    regRdData = 8'h00;
    errors = 0;
    compares = 0;
    for (int i = 0; i < 256; i++) begin
      seed = lfsrNext(seed);
      regMem[i] = seed[7:0];
    end
    regMem[8'h12] = 8'h7E;
    repeat (12) @(negedge ref_clk);
    rstn = 1'b1;
    // Worked examples: one byte folded into the all-ones seed
    check("crcStep2B", {24'h0, src_pkg::crc8_step(8'hFF, 8'h2B)}, 32'h0000_0022);
    check("crcStep7E", {24'h0, src_pkg::crc8_step(8'hFF, 8'h7E)}, 32'h0000_008E);
    // Every mode pair, wrapping address, random back-pressure, back to back
    for (int i = 0; i < 12; i++) begin
      seed = lfsrNext(seed);
      doRead(i == 0 ? 8'hFE : (i == 3 ? 8'h12 : seed[15:8]), i[1], i[0]);
    end
    // Host stalls long: whole frame must wait in the buffer
    pauseHold = 1'b1;
    fork
      doRead(8'h40, 1'b1, 1'b1);
      begin
        repeat (40) @(negedge ref_clk);
        check("devBusy", {31'h0, devBusy}, 32'h0);
        pauseHold = 1'b0;
      end
    join
    // Channels off: the start is dropped silently
    channelsEnabled = 1'b0;
    startRead = 1'b1;
    @(negedge ref_clk);
    startRead = 1'b0;
    repeat (10) @(negedge ref_clk);
    check("hostBusy", {31'h0, hostBusy}, 32'h0);
    check("reqValid", {31'h0, linkIf.reqValid}, 32'h0);
    channelsEnabled = 1'b1;
    doRead(8'hFF, 1'b1, 1'b1);
    // Nothing promised may be left unseen
    check("byteQ", byteQ.size(), 32'h0);
    check("resQ", resQ.size(), 32'h0);
    conclude();
  end
endmodule
